// ### pkg/vlm_pkg.sv
// Constants for the VBI line map and sync reference output block.
// Assumes the register port is driven from the core_clk domain.
package vlm_pkg;

   // Register subaddresses
   localparam logic [7:0] ADDR_SLOT_FIRST = 8'h41;
   localparam logic [7:0] ADDR_SLOT_LAST  = 8'h57;
   localparam logic [7:0] ADDR_PIX_OFF_LO = 8'h59;
   localparam logic [7:0] ADDR_LINE_OFF_LO = 8'h5A;
   localparam logic [7:0] ADDR_OFF_HIGH   = 8'h5B;

   // Fields of offset_high_and_field
   localparam int FIELD_FLAG_BIT = 7;
   localparam int VERTICAL_LINE_OFFSET_MSB_BIT   = 4;
   localparam int HORIZONTAL_PIXEL_OFFSET_HI_MSB    = 2;

   // Reset values
   localparam logic [10:0] HORIZONTAL_PIXEL_OFFSET_RESET  = 11'h347;
   localparam logic [8:0]  VERTICAL_LINE_OFFSET_RESET  = 9'h003;
   localparam logic        FIELD_NUMBERING_FLAG_RESET  = 1'b0;
   localparam logic [7:0]  SLOT_RESET  = 8'hFF;

   // Slot numbering
   localparam logic [4:0] SLOT_FIRST      = 5'h02;
   localparam logic [4:0] SLOT_LAST_INDIV = 5'h17;
   localparam logic [4:0] SLOT_FINAL      = 5'h18;
   localparam int         SLOT_COUNT      = 23;

   // Field-numbering conventions chosen by the field flag; frame lengths chosen by std_60hz
   localparam logic [8:0] VERTICAL_LINE_OFFSET_REF_60    = 9'h006;
   localparam logic [8:0] VERTICAL_LINE_OFFSET_REF_50    = 9'h003;
   localparam logic [9:0] FIELD2_BASE_60 = 10'h107;
   localparam logic [9:0] FIELD2_BASE_50 = 10'h139;
   localparam logic [9:0] FRAME_LINES_60 = 10'h20D;
   localparam logic [9:0] FRAME_LINES_50 = 10'h271;

   // Sources routable to the reference pins
   typedef enum logic [2:0] {
      SRC_HORIZONTAL_REFERENCE, SRC_HSYNC, SRC_VBLANK, SRC_VERTICAL_GATE,
      SRC_FIELD_ID, SRC_CLK_QUAL, SRC_CLK_QUAL_HALF
   } vlm_src_e;
   localparam int SRC_COUNT = 7;

endpackage

// ### logic/vlm_pin_mux.sv
// Routes one of several reference sources to a pin, with optional inversion.
// Assumes sources and select come from the core_clk domain.
`timescale 1ns/1ps
module vlm_pin_mux
   import vlm_pkg::*;
#(
   parameter int N     = 7,
   parameter int SEL_W = 3
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rstn,
   // Sources and control
   input  wire logic [N-1:0]     src,
   input  wire logic [SEL_W-1:0] sel,
   input  wire logic             invert,
   // Pin
   output logic                  pin_out
);

   logic pick;

   always_comb begin
      pick = (32'(sel) < N) ? src[sel] : 1'b0;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pin_out <= 1'b0;
      end else begin
         pin_out <= pick ^ invert;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   chk_pin_routing: assert property (
      ##1 pin_out == ($past(pick) ^ $past(invert)))
      else $error("pin does not follow selected source");
   chk_pin_invert: assert property (
      $rose(invert) |=> pin_out == !$past(pick))
      else $error("inversion not applied");
   cov_pin_inverted: cover property (invert && pin_out);

endmodule

// ### logic/vlm_line_map.sv
// Contract
// - Nine-bit line offset at 5BH[4], 5AH[7:0]
// - Eleven-bit pixel offset at 5BH[2:0], 59H
// - Field flag at 5BH[7] selects field numbering
// - 60 Hz: slot n at n, n+263
// - 50 Hz: slot n at n, n+313
// - Vertical blank fall plus horizontal_reference gives parity
// - Pins carry horizontal_reference, blank, gate, field signals
// - Select pins also carry hsync, clock qualifiers
// - Each select pin has own polarity bit
// - Expansion horizontal pin: horizontal_reference or hsync
// - Upper nibble field one, lower field two
// - Slot 24 holds for remaining field lines
//
// VBI line-type mapping and sync reference generation.
// Assumes register port and all control inputs are in the core_clk domain.
`timescale 1ns/1ps
module vlm_line_map
   import vlm_pkg::*;
#(
   parameter logic [10:0] LINE_LEN_60 = 11'h6B4,
   parameter logic [10:0] LINE_LEN_50 = 11'h6C0,
   parameter logic [10:0] HORIZONTAL_REFERENCE_START  = 11'h110,
   parameter logic [10:0] HORIZONTAL_REFERENCE_LEN    = 11'h5A0,
   parameter logic [10:0] HSYNC_LEN   = 11'h080,
   parameter logic [9:0]  VBLANK_END  = 10'h014,
   parameter logic [9:0]  VERTICAL_GATE_START = 10'h00A,
   parameter logic [9:0]  VERTICAL_GATE_END   = 10'h015
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // Register port
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   // Standard and pin control
   input  wire logic       std_60hz,
   input  wire logic [2:0] rt_select_pin_a_sel,
   input  wire logic [2:0] rt_select_pin_b_sel,
   input  wire logic       rt_pin_a_polarity,
   input  wire logic       rt_pin_b_polarity,
   input  wire logic       expansion_h_ref_sel,
   input  wire logic       expansion_v_ref_sel,
   // Line data type
   output logic [3:0]      line_data_type,
   output logic [4:0]      line_type_slot,
   // Reference pins
   output logic            rt_select_pin_a,
   output logic            rt_select_pin_b,
   output logic            expansion_h_ref_pin,
   output logic            expansion_v_ref_pin
);

   logic [10:0] horizontal_pixel_offset_reg;
   logic [8:0]  vertical_line_offset_reg;
   logic        field_numbering_flag_reg;
   logic [7:0]  slot_mem [SLOT_COUNT];
   logic [10:0] hcnt_reg;
   logic [9:0]  lcnt_reg;
   logic        field2_reg;
   logic        horizontal_reference_reg;
   logic        horizontal_sync_pulse_reg;
   logic        vertical_blank_pulse_reg;
   logic        vertical_gate_reg;
   logic        field_identifier_reg;
   logic        field_signal_656_reg;
   logic        clock_qualifier_reg;
   logic        half_rate_clock_qualifier_reg;
   logic [10:0] line_len;
   logic [9:0]  frame_lines;
   logic [9:0]  field2_base;
   logic [8:0]  vertical_line_offset_ref;
   logic        field2_next;
   logic [9:0]  lif;
   logic [11:0] slot_calc;
   logic        slot_in_range;
   logic [4:0]  slot_next;
   logic [4:0]  slot_wr_idx;
   logic        slot_wr;
   logic        latch_pt;
   logic [6:0]  src_vec;
   logic [1:0]  xrh_src;
   logic [1:0]  xrv_src;

   // Register writes
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         horizontal_pixel_offset_reg <= HORIZONTAL_PIXEL_OFFSET_RESET;
         vertical_line_offset_reg    <= VERTICAL_LINE_OFFSET_RESET;
         field_numbering_flag_reg    <= FIELD_NUMBERING_FLAG_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_PIX_OFF_LO:
               horizontal_pixel_offset_reg[7:0] <= reg_wdata;
            ADDR_LINE_OFF_LO:
               vertical_line_offset_reg[7:0] <= reg_wdata;
            ADDR_OFF_HIGH: begin
               field_numbering_flag_reg <= reg_wdata[FIELD_FLAG_BIT];
               vertical_line_offset_reg[8] <= reg_wdata[VERTICAL_LINE_OFFSET_MSB_BIT];
               horizontal_pixel_offset_reg[10:8] <=
                  reg_wdata[HORIZONTAL_PIXEL_OFFSET_HI_MSB:0];
            end
            default: ;
         endcase
      end
   end
   assign slot_wr_idx = 5'(reg_addr - ADDR_SLOT_FIRST);
   assign slot_wr = reg_wr && reg_addr >= ADDR_SLOT_FIRST &&
                    reg_addr <= ADDR_SLOT_LAST;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         for (int i = 0; i < SLOT_COUNT; i++) begin
            slot_mem[i] <= SLOT_RESET;
         end
      end else if (slot_wr) begin
         slot_mem[slot_wr_idx] <= reg_wdata;
      end
   end

   // Register read-back; reserved bits of 5BH read zero
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr >= ADDR_SLOT_FIRST &&
                   reg_addr <= ADDR_SLOT_LAST) begin
         reg_rdata <= slot_mem[slot_wr_idx];
      end else begin
         case (reg_addr)
            ADDR_PIX_OFF_LO:  reg_rdata <= horizontal_pixel_offset_reg[7:0];
            ADDR_LINE_OFF_LO: reg_rdata <= vertical_line_offset_reg[7:0];
            ADDR_OFF_HIGH:    reg_rdata <= {field_numbering_flag_reg, 2'b00,
                                vertical_line_offset_reg[8], 1'b0,
                                horizontal_pixel_offset_reg[10:8]};
            default:          reg_rdata <= 8'h00;
         endcase
      end
   end

   // Line and frame counters
   assign line_len    = std_60hz ? LINE_LEN_60 : LINE_LEN_50;
   assign frame_lines = std_60hz ? FRAME_LINES_60 : FRAME_LINES_50;
   assign field2_base = field_numbering_flag_reg ? FIELD2_BASE_60
                                                 : FIELD2_BASE_50;
   assign vertical_line_offset_ref    = field_numbering_flag_reg ? VERTICAL_LINE_OFFSET_REF_60
                                                 : VERTICAL_LINE_OFFSET_REF_50;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         hcnt_reg <= 11'h000;
         lcnt_reg <= 10'h001;
      end else if (hcnt_reg >= line_len - 11'h001) begin
         hcnt_reg <= 11'h000;
         lcnt_reg <= (lcnt_reg >= frame_lines) ? 10'h001
                                               : lcnt_reg + 10'h001;
      end else begin
         hcnt_reg <= hcnt_reg + 11'h001;
      end
   end
   assign field2_next = lcnt_reg > field2_base;
   assign lif = field2_next ? lcnt_reg - field2_base : lcnt_reg;

   // Line to slot mapping
   assign slot_calc = {2'b00, lif} + {3'b000, vertical_line_offset_ref}
                      - {3'b000, vertical_line_offset_reg};
   assign slot_in_range = !slot_calc[11] &&
                          slot_calc >= {7'h00, SLOT_FIRST} &&
                          slot_calc <= {7'h00, SLOT_LAST_INDIV};
   assign slot_next = slot_in_range ? slot_calc[4:0] : SLOT_FINAL;
   assign latch_pt  = hcnt_reg == horizontal_pixel_offset_reg;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         line_type_slot <= SLOT_FINAL;
         line_data_type <= 4'h0;
         field2_reg     <= 1'b0;
      end else if (latch_pt) begin
         line_type_slot <= slot_next;
         field2_reg     <= field2_next;
         line_data_type <= field2_next
            ? slot_mem[5'(slot_next - SLOT_FIRST)][3:0]
            : slot_mem[5'(slot_next - SLOT_FIRST)][7:4];
      end
   end

   // Horizontal references and clock qualifiers
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         horizontal_reference_reg      <= 1'b0;
         horizontal_sync_pulse_reg     <= 1'b0;
         clock_qualifier_reg           <= 1'b0;
         half_rate_clock_qualifier_reg <= 1'b0;
      end else begin
         horizontal_reference_reg  <= hcnt_reg >= HORIZONTAL_REFERENCE_START &&
                                      hcnt_reg < HORIZONTAL_REFERENCE_START + HORIZONTAL_REFERENCE_LEN;
         horizontal_sync_pulse_reg <= hcnt_reg < HSYNC_LEN;
         clock_qualifier_reg       <= !clock_qualifier_reg;
         if (clock_qualifier_reg) begin
            half_rate_clock_qualifier_reg <= !half_rate_clock_qualifier_reg;
         end
      end
   end

   // Vertical references; blank falls inside horizontal_reference for field one only
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         vertical_blank_pulse_reg <= 1'b0;
      end else if (lif == 10'h001 && hcnt_reg == 11'h000) begin
         vertical_blank_pulse_reg <= 1'b1;
      end else if (lif == VBLANK_END && hcnt_reg ==
                   (field2_next ? 11'h000 : HORIZONTAL_REFERENCE_START + 11'h001)) begin
         vertical_blank_pulse_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         vertical_gate_reg    <= 1'b0;
         field_identifier_reg <= 1'b0;
         field_signal_656_reg <= 1'b0;
      end else begin
         vertical_gate_reg <= lif >= VERTICAL_GATE_START && lif <= VERTICAL_GATE_END;
         field_identifier_reg <= field2_next;
         if (hcnt_reg == 11'h000) begin
            field_signal_656_reg <= field2_next;
         end
      end
   end

   // Pin routing
   assign src_vec = {half_rate_clock_qualifier_reg, clock_qualifier_reg,
                     field_identifier_reg, vertical_gate_reg,
                     vertical_blank_pulse_reg, horizontal_sync_pulse_reg,
                     horizontal_reference_reg};
   assign xrh_src = {horizontal_sync_pulse_reg, horizontal_reference_reg};
   assign xrv_src = {field_signal_656_reg, vertical_blank_pulse_reg};

   vlm_pin_mux #(.N(SRC_COUNT), .SEL_W(3)) u_rt_a (
      .core_clk (core_clk), .rstn (rstn), .src (src_vec),
      .sel (rt_select_pin_a_sel), .invert (rt_pin_a_polarity),
      .pin_out (rt_select_pin_a));
   vlm_pin_mux #(.N(SRC_COUNT), .SEL_W(3)) u_rt_b (
      .core_clk (core_clk), .rstn (rstn), .src (src_vec),
      .sel (rt_select_pin_b_sel), .invert (rt_pin_b_polarity),
      .pin_out (rt_select_pin_b));
   vlm_pin_mux #(.N(2), .SEL_W(1)) u_xrh (
      .core_clk (core_clk), .rstn (rstn), .src (xrh_src),
      .sel (expansion_h_ref_sel), .invert (1'b0),
      .pin_out (expansion_h_ref_pin));
   vlm_pin_mux #(.N(2), .SEL_W(1)) u_xrv (
      .core_clk (core_clk), .rstn (rstn), .src (xrv_src),
      .sel (expansion_v_ref_sel), .invert (1'b0),
      .pin_out (expansion_v_ref_pin));

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   chk_line_offset_write: assert property (
      reg_wr && reg_addr == ADDR_OFF_HIGH |=>
      vertical_line_offset_reg[8] == $past(reg_wdata[VERTICAL_LINE_OFFSET_MSB_BIT]))
      else $error("line offset msb not stored");
   chk_pixel_offset_write: assert property (
      reg_wr && reg_addr == ADDR_PIX_OFF_LO |=>
      horizontal_pixel_offset_reg[7:0] == $past(reg_wdata))
      else $error("pixel offset low not stored");
   chk_field_flag_write: assert property (
      reg_wr && reg_addr == ADDR_OFF_HIGH |=>
      field_numbering_flag_reg == $past(reg_wdata[FIELD_FLAG_BIT]))
      else $error("field flag not stored");
   chk_field1_map: assert property (
      latch_pt && !field2_next && vertical_line_offset_reg == vertical_line_offset_ref &&
      lcnt_reg >= 10'h002 && lcnt_reg <= 10'h017 |=>
      line_type_slot == $past(lcnt_reg[4:0]))
      else $error("first field line maps to wrong slot");
   chk_field2_map: assert property (
      latch_pt && field2_next && vertical_line_offset_reg == vertical_line_offset_ref &&
      lif >= 10'h002 && lif <= 10'h017 |=>
      line_type_slot == $past(5'(lcnt_reg - field2_base)))
      else $error("second field line maps to wrong slot");
   chk_final_slot: assert property (
      latch_pt && !slot_in_range |=> line_type_slot == SLOT_FINAL)
      else $error("out of range line not on final slot");
   chk_parity_edge: assert property (
      $fell(vertical_blank_pulse_reg) |->
      horizontal_reference_reg == !field_identifier_reg)
      else $error("horizontal_reference at blank fall gives wrong parity");
   chk_nibble_select: assert property (
      latch_pt && !slot_wr |=> line_data_type == (field2_reg
         ? slot_mem[5'(line_type_slot - SLOT_FIRST)][3:0]
         : slot_mem[5'(line_type_slot - SLOT_FIRST)][7:4]))
      else $error("wrong nibble for field");
   chk_xrh_source: assert property (
      ##2 expansion_h_ref_pin == $past(xrh_src[expansion_h_ref_sel]))
      else $error("expansion horizontal pin wrong source");
   cov_field2_fall: cover property (
      $fell(vertical_blank_pulse_reg) && field_identifier_reg);
   cov_field1_fall: cover property (
      $fell(vertical_blank_pulse_reg) && !field_identifier_reg);
   cov_slot_ten_f2: cover property (
      latch_pt && field2_next && slot_next == 5'h0A);
endmodule

// ### dv/vlm_sync_rx.sv
// Far-side receiver model: decodes field parity from the sync references.
// Assumes blank and horizontal_reference arrive as registered levels in core_clk.
`timescale 1ns/1ps
module vlm_sync_rx (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rstn,
   // Sampled references
   input  wire logic vblank,
   input  wire logic horizontal_reference,
   // Decoded field
   output logic      field_odd
);
   logic vblank_reg;

   // Parity is the horizontal_reference level in the cycle the blank fall is seen
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         vblank_reg <= 1'b0;
         field_odd  <= 1'b0;
      end else begin
         vblank_reg <= vblank;
         if (vblank_reg && !vblank) begin
            field_odd <= horizontal_reference;
         end
      end
   end
endmodule

// ### dv/testbench.sv
// Self-checking bench for the line map and sync reference block.
// Assumes a shortened line length so that whole fields fit in the run.
`timescale 1ns/1ps
module testbench;
   import vlm_pkg::*;
   localparam int LN = 32;

   logic       core_clk;
   logic       rstn;
   logic       reg_wr;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       std_60hz;
   logic [2:0] sel_a;
   logic [2:0] sel_b;
   logic       pol_a;
   logic       pol_b;
   logic       xh_sel;
   logic       xv_sel;
   logic [3:0] line_data_type;
   logic [4:0] line_type_slot;
   logic       pin_a;
   logic       pin_b;
   logic       pin_xh;
   logic       pin_xv;
   logic       rx_odd;
   logic [3:0] seen [2:24];
   int         n_fail;
   int         cmp_count;
   int         cyc;

   vlm_line_map #(.LINE_LEN_60(11'h020), .LINE_LEN_50(11'h020),
      .HORIZONTAL_REFERENCE_START(11'h004), .HORIZONTAL_REFERENCE_LEN(11'h014), .HSYNC_LEN(11'h004))
   u_vlm_line_map (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .std_60hz(std_60hz), .rt_select_pin_a_sel(sel_a),
      .rt_select_pin_b_sel(sel_b), .rt_pin_a_polarity(pol_a),
      .rt_pin_b_polarity(pol_b), .expansion_h_ref_sel(xh_sel),
      .expansion_v_ref_sel(xv_sel), .line_data_type(line_data_type),
      .line_type_slot(line_type_slot), .rt_select_pin_a(pin_a),
      .rt_select_pin_b(pin_b), .expansion_h_ref_pin(pin_xh),
      .expansion_v_ref_pin(pin_xv));

   vlm_sync_rx u_vlm_sync_rx (.core_clk(core_clk), .rstn(rstn),
      .vblank(pin_a), .horizontal_reference(pin_b), .field_odd(rx_odd));

   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;

   task automatic final_report;
      if (n_fail == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 80000) begin
         n_fail++;
         $display("mismatch t=%0t timeout", $time);
         final_report;
      end
   end

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      @(posedge core_clk);
      #1;
      cmp(reg_rdata, exp);
   endtask

   task automatic t_regs;
      rdchk(ADDR_PIX_OFF_LO, 8'h47);
      rdchk(ADDR_LINE_OFF_LO, 8'h03);
      rdchk(ADDR_OFF_HIGH, 8'h03);
      rdchk(ADDR_SLOT_FIRST, 8'hFF);
      wr(8'h58, 8'h5A);
      rdchk(8'h58, 8'h00);
      wr(ADDR_OFF_HIGH, 8'hFF);
      rdchk(ADDR_OFF_HIGH, 8'h97);
      for (int n = 2; n <= 24; n++) begin
         wr(ADDR_SLOT_FIRST + 8'(n - 2), {4'(n), ~4'(n)});
      end
      rdchk(ADDR_SLOT_LAST, 8'h87);
   endtask

   // Each source on both select pins, one inverted, plus expansion pins
   task automatic t_pins;
      int hi;
      for (int s = 0; s < 7; s++) begin
         @(posedge core_clk);
         sel_a  <= 3'(s);
         sel_b  <= 3'(s);
         pol_b  <= 1'b1;
         xh_sel <= (s == 1);
         xv_sel <= 1'b0;
         repeat (4) @(posedge core_clk);
         hi = 0;
         for (int k = 0; k < LN; k++) begin
            @(posedge core_clk);
            #1;
            cmp(8'(pin_b), {7'h00, ~pin_a});
            if (s < 2) cmp(8'(pin_xh), 8'(pin_a));
            if (s == 2) cmp(8'(pin_xv), 8'(pin_a));
            hi += (pin_a === 1'b1);
         end
         if (s == 0) cmp(8'(hi), 8'h14);
      end
      xv_sel <= 1'b1;
   endtask

   // Follows one field from the blank rise through the final slot
   task automatic scan_field(output logic odd);
      int   w;
      logic prev;
      w    = 0;
      prev = 1'b1;
      while (!(pin_a === 1'b1 && prev === 1'b0) && w < 25000) begin
         prev = pin_a;
         @(posedge core_clk);
         #1;
         w++;
      end
      w = 0;
      while (line_type_slot !== 5'h02 && w < 3 * LN) begin
         @(posedge core_clk);
         #1;
         w++;
      end
      for (int n = 2; n <= 24; n++) begin
         cmp(8'(line_type_slot), 8'(n));
         seen[n] = line_data_type;
         repeat (LN) @(posedge core_clk);
         #1;
      end
      cmp(8'(line_type_slot), 8'(SLOT_FINAL));
      cmp(8'(line_data_type), 8'(seen[24]));
      odd = rx_odd;
      cmp(8'(pin_xv), {7'h00, ~odd});
      for (int n = 2; n <= 24; n++) begin
         cmp(8'(seen[n]), {4'h0, odd ? 4'(n) : ~4'(n)});
      end
   endtask

   task automatic t_map(input logic std, input logic [7:0] vertical_line_offset,
                        input logic [7:0] hi);
      logic p0;
      logic p1;
      @(posedge core_clk);
      std_60hz <= std;
      sel_a    <= 3'h2;
      sel_b    <= 3'h0;
      pol_b    <= 1'b0;
      wr(ADDR_PIX_OFF_LO, 8'h08);
      wr(ADDR_LINE_OFF_LO, vertical_line_offset);
      wr(ADDR_OFF_HIGH, hi);
      rdchk(ADDR_LINE_OFF_LO, vertical_line_offset);
      rdchk(ADDR_OFF_HIGH, hi);
      scan_field(p0);
      scan_field(p1);
      cmp(8'(p0 ^ p1), 8'h01);
   endtask

   initial begin
      n_fail    = 0;
      cmp_count = 0;
      cyc       = 0;
      rstn      = 1'b0;
      reg_wr    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      std_60hz  = 1'b1;
      sel_a     = 3'h0;
      sel_b     = 3'h0;
      pol_a     = 1'b0;
      pol_b     = 1'b0;
      xh_sel    = 1'b0;
      xv_sel    = 1'b0;
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      #1;
      cmp(8'(line_type_slot), 8'(SLOT_FINAL));
      t_regs;
      t_pins;
      t_map(1'b1, 8'h06, 8'h80);
      t_map(1'b0, 8'h03, 8'h00);
      final_report;
   end
endmodule
